// File: verilog/fcp_pkg.sv
// constants shared by the four-channel pulse width modulator files
package fcp_pkg;

  // ----------------------------------------------------------------
  // data widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CHANNELS = 4;
  localparam int unsigned APB_ADDR_W = 12;
  localparam int unsigned APB_DATA_W = 32;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL = 8'hF1;
  localparam logic [7:0] IDX_PRESCALE_CH3 = 8'hF3;
  localparam logic [7:0] IDX_DUTY_CH2 = 8'hF4;
  localparam logic [7:0] IDX_DUTY_CH3 = 8'hF5;
  localparam logic [7:0] IDX_PRESCALE_CH2 = 8'hF6;
  localparam logic [7:0] IDX_PRESCALE_CH1 = 8'hFB;
  localparam logic [7:0] IDX_DUTY_CH0 = 8'hFC;
  localparam logic [7:0] IDX_DUTY_CH1 = 8'hFD;
  localparam logic [7:0] IDX_PRESCALE_CH0 = 8'hFE;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int unsigned BIT_CH0_OUTPUT_ENABLE = 0;
  localparam int unsigned BIT_CH1_OUTPUT_ENABLE = 1;
  localparam int unsigned BIT_MODULE_A_DUAL_SINGLE_SELECT = 2;
  localparam int unsigned BIT_CH2_OUTPUT_ENABLE = 4;
  localparam int unsigned BIT_CH3_OUTPUT_ENABLE = 5;
  localparam int unsigned BIT_MODULE_B_DUAL_SINGLE_SELECT = 6;
  localparam int unsigned BIT_FUNCTION_DISABLE = 7;
  // bit 3 is reserved: never stored, reads zero
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hF7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic IDLE_LEVEL = 1'b1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [7:0] COUNT_LAST = 8'hFE;
  localparam logic [7:0] COUNT_FIRST = 8'h00;
  localparam int unsigned OSC_PREDIVIDE = 2;

endpackage

// File: verilog/fcp_timebase_if.sv
// link between the register front end and one prescaler/counter time base
`timescale 1ns/1ps
interface fcp_timebase_if;
  logic [7:0] prescale_value;
  logic run;
  logic [7:0] count;
  logic step;

  modport ctrl (
    output prescale_value,
    output run,
    input count,
    input step
  );

  modport base (
    input prescale_value,
    input run,
    output count,
    output step
  );
endinterface

// File: verilog/fcp_timebase.sv
// one prescaler feeding a modulo-255 counter
`timescale 1ns/1ps
module fcp_timebase (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // oscillator divided by two, one-cycle pulse
  input wire logic half_tick,
  // control and count
  fcp_timebase_if.base tb
);

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  logic [7:0] pre_reg;
  logic [7:0] count_reg;
  logic pre_done;

  assign pre_done = half_tick && (pre_reg >= tb.prescale_value);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pre_reg <= 8'h00;
    end else if (ce) begin
      if (!tb.run) begin
        pre_reg <= 8'h00;
      end else if (pre_done) begin
        pre_reg <= 8'h00;
      end else if (half_tick) begin
        pre_reg <= pre_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // step 0..254 then wrap
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_reg <= fcp_pkg::COUNT_FIRST;
    end else if (ce) begin
      if (!tb.run) begin
        count_reg <= fcp_pkg::COUNT_FIRST;
      end else if (pre_done) begin
        if (count_reg >= fcp_pkg::COUNT_LAST) begin
          count_reg <= fcp_pkg::COUNT_FIRST;
        end else begin
          count_reg <= count_reg + 8'h01;
        end
      end
    end
  end

  assign tb.count = count_reg;
  assign tb.step = pre_done;

endmodule

// File: verilog/fcp_top.sv
// four-channel pulse width modulator with an apb register port
//
// Contract
// - each counter is clocked by an 8-bit prescaler dividing by value plus one
// - each counter counts modulo 255, from 0 through 254, then wraps
// - output is low while duty value is greater than its counter
// - output is high while duty value is equal to or below its counter
// - duty 00 gives constant high, duty FF gives constant low
// - a new duty value takes effect at once, not at period end
// - dual mode: ch0/ch1 share time base A, ch2/ch3 share time base B
// - all four channels can also run independently with own prescalers
// - module A select: clear means dual, set means single output
// - module B select: clear means dual, set means single output
// - function disable bit set stops the modulator, clear enables it
// - each channel has its own output enable bit in the control register
// - low to high time ratio is duty over 255 minus duty
// - after reset the four pins are modulator outputs, push-pull driven
// - pulse-width ratio programmable from 0 to 1 in 1/255 steps
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module fcp_top (
  // clock, reset and freeze
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fcp_pkg::APB_ADDR_W-1:0] paddr,
  input wire logic [fcp_pkg::APB_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [fcp_pkg::APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // modulator pins, push-pull
  output logic [fcp_pkg::CHANNELS-1:0] pwm_out
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] pulse_module_control_reg;
  logic [7:0] prescale_reg [fcp_pkg::CHANNELS];
  logic [7:0] duty_reg [fcp_pkg::CHANNELS];
  logic [fcp_pkg::APB_DATA_W-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [fcp_pkg::CHANNELS-1:0] pwm_out_reg;
  logic half_reg;

  // control fields
  logic function_disable_bit;
  logic module_a_dual_single_select;
  logic module_b_dual_single_select;
  logic [fcp_pkg::CHANNELS-1:0] output_enable;

  assign function_disable_bit = pulse_module_control_reg[fcp_pkg::BIT_FUNCTION_DISABLE];
  assign module_a_dual_single_select =
    pulse_module_control_reg[fcp_pkg::BIT_MODULE_A_DUAL_SINGLE_SELECT];
  assign module_b_dual_single_select =
    pulse_module_control_reg[fcp_pkg::BIT_MODULE_B_DUAL_SINGLE_SELECT];
  assign output_enable = {
    pulse_module_control_reg[fcp_pkg::BIT_CH3_OUTPUT_ENABLE],
    pulse_module_control_reg[fcp_pkg::BIT_CH2_OUTPUT_ENABLE],
    pulse_module_control_reg[fcp_pkg::BIT_CH1_OUTPUT_ENABLE],
    pulse_module_control_reg[fcp_pkg::BIT_CH0_OUTPUT_ENABLE]
  };

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // one wait state: pready rises in the second access cycle, so the
  // data path is a clean flop and the write lands one edge later, as the transfer ends
  logic apb_access;
  logic apb_done;
  logic [7:0] reg_index;
  logic addr_aligned;
  logic addr_in_page;
  logic hit_control;
  logic [fcp_pkg::CHANNELS-1:0] hit_prescale;
  logic [fcp_pkg::CHANNELS-1:0] hit_duty;
  logic addr_mapped;
  logic wr_en;

  assign apb_access = psel && penable;
  assign apb_done = apb_access && pready_reg;
  assign reg_index = paddr[9:2];
  assign addr_aligned = (paddr[1:0] == 2'h0);
  assign addr_in_page = (paddr[fcp_pkg::APB_ADDR_W-1:10] == 2'h0);
  assign hit_control = (reg_index == fcp_pkg::IDX_CONTROL);
  assign hit_prescale = {
    reg_index == fcp_pkg::IDX_PRESCALE_CH3,
    reg_index == fcp_pkg::IDX_PRESCALE_CH2,
    reg_index == fcp_pkg::IDX_PRESCALE_CH1,
    reg_index == fcp_pkg::IDX_PRESCALE_CH0
  };
  assign hit_duty = {
    reg_index == fcp_pkg::IDX_DUTY_CH3,
    reg_index == fcp_pkg::IDX_DUTY_CH2,
    reg_index == fcp_pkg::IDX_DUTY_CH1,
    reg_index == fcp_pkg::IDX_DUTY_CH0
  };
  assign addr_mapped = addr_aligned && addr_in_page &&
    (hit_control || (|hit_prescale) || (|hit_duty));
  // only byte lane 0 carries register data
  assign wr_en = apb_done && pwrite && addr_mapped && pstrb[0];

  // one write select per register, so a refused write reaches no flop
  logic wr_control;
  logic [fcp_pkg::CHANNELS-1:0] wr_prescale;
  logic [fcp_pkg::CHANNELS-1:0] wr_duty;

  assign wr_control = wr_en && hit_control;
  assign wr_prescale = {fcp_pkg::CHANNELS{wr_en}} & hit_prescale;
  assign wr_duty = {fcp_pkg::CHANNELS{wr_en}} & hit_duty;

  // ----------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready_reg <= 1'b0;
    end else if (ce) begin
      pready_reg <= apb_access && !pready_reg;
    end
  end

  // error is registered beside ready so both rise on the same edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pslverr_reg <= 1'b0;
    end else if (ce) begin
      pslverr_reg <= apb_access && !pready_reg && !addr_mapped;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] read_byte;

  // unmapped or misaligned offsets read zero; pslverr flags them
  always_comb begin
    read_byte = 8'h00;
    if (addr_aligned && addr_in_page) begin
      unique case (reg_index)
        fcp_pkg::IDX_CONTROL: begin
          read_byte = pulse_module_control_reg;
        end
        fcp_pkg::IDX_PRESCALE_CH0: begin
          read_byte = prescale_reg[0];
        end
        fcp_pkg::IDX_PRESCALE_CH1: begin
          read_byte = prescale_reg[1];
        end
        fcp_pkg::IDX_PRESCALE_CH2: begin
          read_byte = prescale_reg[2];
        end
        fcp_pkg::IDX_PRESCALE_CH3: begin
          read_byte = prescale_reg[3];
        end
        fcp_pkg::IDX_DUTY_CH0: begin
          read_byte = duty_reg[0];
        end
        fcp_pkg::IDX_DUTY_CH1: begin
          read_byte = duty_reg[1];
        end
        fcp_pkg::IDX_DUTY_CH2: begin
          read_byte = duty_reg[2];
        end
        fcp_pkg::IDX_DUTY_CH3: begin
          read_byte = duty_reg[3];
        end
        default: begin
          read_byte = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata_reg <= 32'h00000000;
    end else if (ce) begin
      if (apb_access && !pready_reg && !pwrite) begin
        prdata_reg <= {24'h000000, read_byte};
      end else begin
        prdata_reg <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // reserved bit 3 is masked, so it always reads back zero
  // select bits stored here
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pulse_module_control_reg <= fcp_pkg::CONTROL_RESET;
    end else if (ce && wr_control) begin
      pulse_module_control_reg <= pwdata[7:0] & fcp_pkg::CONTROL_WRITE_MASK;
    end
  end

  genvar g;
  generate
    for (g = 0; g < fcp_pkg::CHANNELS; g++) begin : g_regs
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          prescale_reg[g] <= fcp_pkg::PRESCALE_RESET;
        end else if (ce && wr_prescale[g]) begin
          prescale_reg[g] <= pwdata[7:0];
        end
      end

      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          duty_reg[g] <= fcp_pkg::DUTY_RESET;
        end else if (ce && wr_duty[g]) begin
          duty_reg[g] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // oscillator divide by two
  // ----------------------------------------------------------------
  // half-rate tick feeds every prescaler
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      half_reg <= 1'b0;
    end else if (ce) begin
      half_reg <= !half_reg;
    end
  end

  // ----------------------------------------------------------------
  // time bases
  // ----------------------------------------------------------------
  // four bases exist; in dual mode the odd one of each pair idles and
  // its channel borrows the even base, so one prescaler sets both
  // leaving dual mode starts the odd base from zero, so the split
  // channel begins a fresh period out of step with its partner
  logic [fcp_pkg::CHANNELS-1:0] single_mode;
  logic [7:0] chan_count [fcp_pkg::CHANNELS];
  // counts leave each base here, so routing needs no path into it
  logic [7:0] base_count [fcp_pkg::CHANNELS];

  // module B select applies to ch2/ch3
  assign single_mode = {
    module_b_dual_single_select, module_b_dual_single_select,
    module_a_dual_single_select, module_a_dual_single_select
  };

  generate
    for (g = 0; g < fcp_pkg::CHANNELS; g++) begin : g_base
      fcp_timebase_if tb_if ();

      assign tb_if.prescale_value = prescale_reg[g];
      // disable bit holds all counters at zero
      // odd bases run only in single mode
      assign tb_if.run = !function_disable_bit && ((g % 2 == 0) || single_mode[g]);

      fcp_timebase u_timebase (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .half_tick(half_reg),
        .tb(tb_if.base)
      );
      assign base_count[g] = tb_if.count;
    end

    for (g = 0; g < fcp_pkg::CHANNELS; g++) begin : g_route
      if (g % 2 == 0) begin : g_even
        assign chan_count[g] = base_count[g];
      end else begin : g_odd
        // dual mode shares the pair's even counter
        assign chan_count[g] = single_mode[g] ? base_count[g]
                                              : base_count[g-1];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // channel gating and compare
  // ----------------------------------------------------------------
  // one bit per channel each, so the pin flops below only pick a level
  logic [fcp_pkg::CHANNELS-1:0] chan_active;
  logic [fcp_pkg::CHANNELS-1:0] chan_low;

  generate
    for (g = 0; g < fcp_pkg::CHANNELS; g++) begin : g_cmp
      // disable bit and enable bit both gate the pin
      assign chan_active[g] = !function_disable_bit && output_enable[g];
      // the count never reaches FF, so FF stays above it
      assign chan_low[g] = duty_reg[g] > chan_count[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // compare and pin drive
  // ----------------------------------------------------------------
  // duty is compared straight from its register so a write shows on the
  // pin one edge after it lands, mid-period; the counter never reaches FF, so
  // FF is constant low and 00 constant high
  generate
    for (g = 0; g < fcp_pkg::CHANNELS; g++) begin : g_out
      // pins start as push-pull modulator outputs at idle high
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          pwm_out_reg[g] <= fcp_pkg::IDLE_LEVEL;
        end else if (ce) begin
          // disabled channel parks at idle level
          if (!chan_active[g]) begin
            pwm_out_reg[g] <= fcp_pkg::IDLE_LEVEL;
          end else if (chan_low[g]) begin
            pwm_out_reg[g] <= 1'b0;
          // high while duty at or below count
          end else begin
            pwm_out_reg[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every port comes straight from its flop, with no gate after it
  // follow from 255-step compare above
  assign pwm_out = pwm_out_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

endmodule

// File: testbench/fcp_assertions.sv
// concurrent checks on the ports of the pulse width modulator
`timescale 1ns/1ps
module fcp_assertions (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic [3:0] pwm_out
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  sequence s_wait;
    psel && penable && ce && !pready;
  endsequence
  sequence s_ctrl_wr;
    psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h3C4;
  endsequence
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_ready_in_access;
    pready |-> psel && penable;
  endproperty
  property p_ready_bound;
    s_wait |-> ##[1:2] pready;
  endproperty
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  property p_misalign_err;
    pready && paddr[1:0] != 2'b00 |-> pslverr && prdata == 32'h0;
  endproperty
  property p_disable_idle;
    s_ctrl_wr ##0 pwdata[7] |-> ##[1:3] (pwm_out == 4'hF) [*4];
  endproperty
  property p_enable_gate;
    s_ctrl_wr ##0 !pwdata[0] |-> ##[1:3] pwm_out[0] [*4];
  endproperty
  property p_reset_idle;
    $fell(rst) |-> pwm_out == 4'hF;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access");
  a_ready_bound: assert property (p_ready_bound) else $error("ready late");
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
  a_misalign_err: assert property (p_misalign_err) else $error("misaligned not refused");
  a_disable_idle: assert property (p_disable_idle) else $error("pins not idle");
  a_enable_gate: assert property (p_enable_gate) else $error("channel not gated");
  a_reset_idle: assert property (p_reset_idle) else $error("pins wrong after reset");
endmodule
bind fcp_top fcp_assertions chk (.clock(clock), .rst(rst), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out));

// File: testbench/fcp_load_model.sv
// loads on the four pins: low time per channel and pair mismatch counts
`timescale 1ns/1ps
module fcp_load_model (
  // clock and window clear
  input wire logic clock,
  input wire logic clr,
  // pins under load
  input wire logic [3:0] pin,
  // measurements
  output logic [15:0] low_cnt [4],
  output logic [15:0] diff01,
  output logic [15:0] diff23
);
  // push-pull pins need no pull level; an unknown never counts as low
  always @(posedge clock) begin
    if (clr) begin
      low_cnt <= '{16'h0, 16'h0, 16'h0, 16'h0};
      diff01 <= 16'h0;
      diff23 <= 16'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pin[i] === 1'b0) low_cnt[i] <= low_cnt[i] + 16'h1;
      end
      if (pin[0] !== pin[1]) diff01 <= diff01 + 16'h1;
      if (pin[2] !== pin[3]) diff23 <= diff23 + 16'h1;
    end
  end
endmodule

// File: testbench/four_channel_pulse_width_modulator_tb.sv
// self-checking bench for the four-channel pulse width modulator
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin num_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module four_channel_pulse_width_modulator_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] pwm_out;
  logic ce = 1'b1;
  logic [3:0] pstrb = 4'hF;
  logic clr = 1'b0;
  logic [15:0] low_cnt [4];
  logic [15:0] diff01;
  logic [15:0] diff23;
  logic [15:0] ex [4];
  logic [31:0] rd;
  logic er;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  localparam logic [7:0] IDX [9] = '{fcp_pkg::IDX_CONTROL, fcp_pkg::IDX_PRESCALE_CH3,
    fcp_pkg::IDX_DUTY_CH2, fcp_pkg::IDX_DUTY_CH3, fcp_pkg::IDX_PRESCALE_CH2,
    fcp_pkg::IDX_PRESCALE_CH1, fcp_pkg::IDX_DUTY_CH0, fcp_pkg::IDX_DUTY_CH1,
    fcp_pkg::IDX_PRESCALE_CH0};

  always #5 clock = ~clock;

  fcp_top uut (.clock(clock), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_out(pwm_out));
  fcp_load_model ld (.clock(clock), .clr(clr), .pin(pwm_out), .low_cnt(low_cnt),
    .diff01(diff01), .diff23(diff23));

  // ----------------------------------------
  // bus and measurement tasks
  // ----------------------------------------
  task automatic end_of_test();
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // full apb transfer; waits for pready without assuming its latency
  task automatic acc(input logic w, input logic [7:0] i, input logic [31:0] d,
                     input logic [1:0] lo = 2'b00);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, lo};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // counts low cycles over a window of whole periods
  task automatic meas(input int win);
    repeat (8) @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    repeat (win) @(posedge clock);
    #1;
    for (int i = 0; i < 4; i++) `CHK("low time", ex[i], low_cnt[i])
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 12000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    `CHK("pins after reset", 4'hF, pwm_out)
    for (int i = 0; i < 9; i++) begin
      acc(1'b0, IDX[i], 32'h0);
      `CHK("reset value", 32'h0, rd)
    end
    acc(1'b0, 8'h00, 32'h0);
    `CHK("unmapped error", 1'b1, er)
    acc(1'b1, fcp_pkg::IDX_DUTY_CH0, 32'hFF, 2'b01);
    `CHK("misaligned error", 1'b1, er)
    // a write with lane 0 off is dropped without an error
    pstrb <= 4'h0;
    acc(1'b1, fcp_pkg::IDX_DUTY_CH0, 32'hAA);
    pstrb <= 4'hF;
    `CHK("strobe error", 1'b0, er)
    acc(1'b0, fcp_pkg::IDX_DUTY_CH0, 32'h0);
    `CHK("strobe ignored", 32'h0, rd)
    acc(1'b1, fcp_pkg::IDX_CONTROL, 32'hFF);
    acc(1'b0, fcp_pkg::IDX_CONTROL, 32'h0);
    `CHK("control readback", 32'hF7, rd)
    `CHK("pins disabled", 4'hF, pwm_out)
    // dual mode: ch1 follows ch0 time base, ch3 follows ch2
    acc(1'b1, fcp_pkg::IDX_PRESCALE_CH2, 32'h01);
    acc(1'b1, fcp_pkg::IDX_DUTY_CH0, 32'h80);
    acc(1'b1, fcp_pkg::IDX_DUTY_CH1, 32'h80);
    acc(1'b1, fcp_pkg::IDX_DUTY_CH2, 32'h01);
    acc(1'b1, fcp_pkg::IDX_DUTY_CH3, 32'h01);
    acc(1'b1, fcp_pkg::IDX_CONTROL, 32'h33);
    ex = '{16'd512, 16'd512, 16'd4, 16'd4};
    meas(1020);
    `CHK("pair a shared", 16'h0, diff01)
    `CHK("pair b shared", 16'h0, diff23)
    // single mode: each channel its own prescaler; duty 00 and FF
    acc(1'b1, fcp_pkg::IDX_PRESCALE_CH1, 32'h03);
    acc(1'b1, fcp_pkg::IDX_DUTY_CH2, 32'h00);
    acc(1'b1, fcp_pkg::IDX_DUTY_CH3, 32'hFF);
    acc(1'b1, fcp_pkg::IDX_CONTROL, 32'h77);
    ex = '{16'd1024, 16'd1024, 16'd0, 16'd2040};
    meas(2040);
    `CHK("pair a split", 1'b1, diff01 != 16'h0)
    acc(1'b1, fcp_pkg::IDX_DUTY_CH3, 32'h00);
    repeat (2) @(posedge clock);
    #1;
    `CHK("duty update", 1'b1, pwm_out[3])
    acc(1'b1, fcp_pkg::IDX_CONTROL, 32'h76);
    ex = '{16'd0, 16'd1024, 16'd0, 16'd0};
    meas(2040);
    acc(1'b1, fcp_pkg::IDX_CONTROL, 32'hF7);
    ex = '{16'd0, 16'd0, 16'd0, 16'd0};
    meas(2040);
    // enable lands, then the freeze keeps the pins at idle until released
    acc(1'b1, fcp_pkg::IDX_CONTROL, 32'h77);
    ce <= 1'b0;
    repeat (20) @(posedge clock);
    #1;
    `CHK("frozen pins", 4'hF, pwm_out)
    @(posedge clock);
    ce <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    `CHK("released pins", 4'hC, pwm_out)
    end_of_test();
  end
endmodule
